// ==== include/exec_pkg.sv ====
// shared constants, types and decode helpers for the skip/xor execution block
package exec_pkg;
    // instruction word layout
    localparam logic [15:0] OP_TST_MASK = 16'hFE00;
    localparam logic [15:0] OP_TST_CODE = 16'h6600;
    localparam logic [7:0] OP_XOR_CODE = 8'h0A;
    localparam int OP_HI_LSB = 8;
    localparam int A_BIT = 8;
    // data address space
    localparam logic [7:0] LIT_OFFSET_MAX = 8'h5F;
    localparam logic [7:0] ACCESS_SPLIT = 8'h60;
    localparam logic [3:0] ACCESS_HI_BANK = 4'hF;
    localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
    // register map, byte addresses
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ACC = 8'h04;
    localparam logic [7:0] REG_STAT = 8'h08;
    localparam logic [7:0] REG_SKIPS = 8'h0C;
    // control fields
    localparam int CTRL_XINST_BIT = 8;
    localparam int CTRL_BSR_MSB = 3;
    // status fields
    localparam int STAT_N_BIT = 0;
    localparam int STAT_Z_BIT = 1;
    localparam int STAT_SKIP_BIT = 2;
    // reset values
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [3:0] BSR_RST = 4'h0;
    localparam logic [15:0] SKIPS_RST = 16'h0000;
    // bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // one fetched word and whether it is the first of a two-word instruction
    typedef struct packed {
        logic two_word;
        logic [15:0] word;
    } instr_t;
    // software-steered control bits
    typedef struct packed {
        logic xinst;
        logic [3:0] bank_select_register;
    } ctrl_t;
    // execution sequencing
    typedef enum logic [1:0] {ST_EXEC, ST_SKIP1, ST_SKIP2} exec_state_t;
    // test-and-skip opcode match
    function automatic logic is_test_skip(input logic [15:0] w);
        return (w & OP_TST_MASK) == OP_TST_CODE;
    endfunction
    // xor-immediate opcode match
    function automatic logic is_xor_imm(input logic [15:0] w);
        return w[15:OP_HI_LSB] == OP_XOR_CODE;
    endfunction
    // mapped register offsets
    function automatic logic addr_hit(input logic [7:0] a);
        return a == REG_CTRL || a == REG_ACC || a == REG_STAT || a == REG_SKIPS;
    endfunction
endpackage

// ==== verilog/file_addr_gen.sv ====
// file-register address formation for the test-and-skip instruction
`timescale 1ns/1ps
`default_nettype none
module file_addr_gen
    import exec_pkg::*;
(
    input wire logic [7:0] f,
    input wire logic a,
    input wire ctrl_t ctrl,
    input wire logic [11:0] idx_base,
    output logic [11:0] addr
);
    // three ways to reach a file register; indexed wins inside the access bank
    always_comb begin
        if (a) begin
            // banked space, bank chosen by the bank select register
            addr = {ctrl.bank_select_register, f};
        end else if (ctrl.xinst && f <= LIT_OFFSET_MAX) begin
            // literal offset from the index base; wrap is intended
            addr = idx_base + {4'h0, f};
        end else if (f < ACCESS_SPLIT) begin
            // low half of the access bank
            addr = {ACCESS_LO_BANK, f};
        end else begin
            // upper half of the access bank maps to the special registers
            addr = {ACCESS_HI_BANK, f};
        end
    end
endmodule
`default_nettype wire

// ==== verilog/axil_port.sv ====
// axi4-lite slave front end: one write and one read at a time
`timescale 1ns/1ps
`default_nettype none
module axil_port
    import exec_pkg::*;
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic reg_we,
    output logic [7:0] reg_waddr,
    output logic [31:0] reg_wdata,
    output logic [3:0] reg_wstrb,
    output logic [7:0] reg_raddr,
    input wire logic [31:0] reg_rdata
);
    logic wr_take; // address and data taken together
    logic rd_take; // read address taken

    // both write channels are taken in the same edge, so order never matters
    assign wr_take = awvalid && wvalid && !bvalid;
    assign awready = wr_take;
    assign wready = wr_take;
    assign rd_take = arvalid && !rvalid;
    assign arready = !rvalid;
    // register strobe for the core, pulse in the take cycle
    assign reg_we = wr_take && addr_hit(awaddr);
    assign reg_waddr = awaddr;
    assign reg_wdata = wdata;
    assign reg_wstrb = wstrb;
    assign reg_raddr = araddr;

    // write response one edge after the take, held until bready
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else if (wr_take) begin
            bvalid <= 1'b1;
            bresp <= addr_hit(awaddr) ? RESP_OKAY : RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // read data captured at the take, held until rready
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rvalid <= 1'b0;
            rresp <= RESP_OKAY;
            rdata <= 32'h00000000;
        end else if (rd_take) begin
            rvalid <= 1'b1;
            rresp <= addr_hit(araddr) ? RESP_OKAY : RESP_SLVERR;
            rdata <= addr_hit(araddr) ? reg_rdata : 32'h00000000;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ==== verilog/skip_xor_exec.sv ====
// execution of test-file-skip-if-zero and xor-immediate-into-accumulator
// Functional notes
// - zero file register: discard next, run nop
// - a=0 selects the access bank
// - a=1 uses bank select register
// - a=0, extended set, f<=5F: indexed offset
// - skipped two-word instruction: three cycles total
// - xor immediate into accumulator, sets n,z
`timescale 1ns/1ps
`default_nettype none
module skip_xor_exec
    import exec_pkg::*;
(
    input wire logic ref_clk,
    input wire logic resetn,
    // register bus
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // fetch stage
    input wire logic instr_valid,
    input wire instr_t instr,
    output logic instr_ready,
    // index base for literal offset addressing
    input wire logic [11:0] idx_base,
    // data memory read port, answers in the same cycle
    output logic mem_rd,
    output logic [11:0] mem_addr,
    input wire logic [7:0] mem_rdata,
    // core state
    output logic [7:0] acc,
    output logic flag_n,
    output logic flag_z,
    output logic skipping
);
    logic reg_we; // register write strobe
    logic [7:0] reg_waddr; // register write offset
    logic [31:0] reg_wdata; // register write data
    logic [3:0] reg_wstrb; // register byte enables
    logic [7:0] reg_raddr; // register read offset
    logic [31:0] reg_rdata; // register read value
    ctrl_t ctrl_r; // extended set enable and bank select
    logic [7:0] acc_r; // working accumulator
    logic flag_n_r; // negative flag
    logic flag_z_r; // zero flag
    logic [15:0] skips_r; // count of taken skips
    exec_state_t state_r; // sequencing state
    exec_state_t state_nxt; // next sequencing state
    logic take; // instruction word consumed this edge
    logic run; // consumed word is executed, not discarded
    logic do_tst; // executing a test-and-skip
    logic do_xor; // executing an xor-immediate
    logic [7:0] xor_res; // xor result
    logic skip_hit; // tested file register is zero

    // bus front end
    axil_port u_axil (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .awaddr(awaddr),
        .awvalid(awvalid),
        .awready(awready),
        .wdata(wdata),
        .wstrb(wstrb),
        .wvalid(wvalid),
        .wready(wready),
        .bresp(bresp),
        .bvalid(bvalid),
        .bready(bready),
        .araddr(araddr),
        .arvalid(arvalid),
        .arready(arready),
        .rdata(rdata),
        .rresp(rresp),
        .rvalid(rvalid),
        .rready(rready),
        .reg_we(reg_we),
        .reg_waddr(reg_waddr),
        .reg_wdata(reg_wdata),
        .reg_wstrb(reg_wstrb),
        .reg_raddr(reg_raddr),
        .reg_rdata(reg_rdata)
    );

    // address of the tested file register
    file_addr_gen u_addr (
        .f(instr.word[7:0]),
        .a(instr.word[A_BIT]),
        .ctrl(ctrl_r),
        .idx_base(idx_base),
        .addr(mem_addr)
    );

    // every cycle with instr_valid takes one word; a discarded word still costs its cycle
    assign instr_ready = 1'b1;
    assign take = instr_valid && instr_ready;
    assign run = take && state_r == ST_EXEC;
    assign do_tst = run && is_test_skip(instr.word);
    assign do_xor = run && is_xor_imm(instr.word);
    // read only: the file register is never written back
    assign mem_rd = do_tst;
    assign skip_hit = mem_rdata == 8'h00;
    assign xor_res = acc_r ^ instr.word[7:0];

    // skip sequencing
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_EXEC: begin
                // zero reads arm the discard of the next word
                if (do_tst && skip_hit) begin
                    state_nxt = ST_SKIP1;
                end
            end
            ST_SKIP1: begin
                // discarded word is a two-word instruction: drop its tail too
                if (take) begin
                    state_nxt = instr.two_word ? ST_SKIP2 : ST_EXEC;
                end
            end
            ST_SKIP2: begin
                // second word of the skipped instruction is also a nop
                if (take) begin
                    state_nxt = ST_EXEC;
                end
            end
            default: begin
                // unused state code: go back to executing rather than lock up
                state_nxt = ST_EXEC;
            end
        endcase
    end

    // state register
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= ST_EXEC;
        end else begin
            state_r <= state_nxt;
        end
    end

    // accumulator: an instruction write beats a bus write in the same edge
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            acc_r <= ACC_RST;
        end else if (do_xor) begin
            // xor with the literal, one cycle
            acc_r <= xor_res;
        end else if (reg_we && reg_waddr == REG_ACC && reg_wstrb[0]) begin
            acc_r <= reg_wdata[7:0];
        end
    end

    // flags move only on xor; test-and-skip leaves them alone
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            flag_n_r <= 1'b0;
            flag_z_r <= 1'b0;
        end else if (do_xor) begin
            // negative and zero from the result
            flag_n_r <= xor_res[7];
            flag_z_r <= xor_res == 8'h00;
        end
    end

    // control register: bank select in byte 0, extended set in byte 1
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_r <= '{xinst: 1'b0, bank_select_register: BSR_RST};
        end else if (reg_we && reg_waddr == REG_CTRL) begin
            if (reg_wstrb[0]) begin
                ctrl_r.bank_select_register <= reg_wdata[CTRL_BSR_MSB:0];
            end
            if (reg_wstrb[1]) begin
                ctrl_r.xinst <= reg_wdata[CTRL_XINST_BIT];
            end
        end
    end

    // taken skips, wraps silently; read only for software
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            skips_r <= SKIPS_RST;
        end else if (do_tst && skip_hit) begin
            skips_r <= skips_r + 16'h0001;
        end
    end

    // register read mux; unmapped offsets are refused by the front end
    always_comb begin
        reg_rdata = 32'h00000000;
        unique case (reg_raddr)
            REG_CTRL: begin
                reg_rdata[CTRL_BSR_MSB:0] = ctrl_r.bank_select_register;
                reg_rdata[CTRL_XINST_BIT] = ctrl_r.xinst;
            end
            REG_ACC: reg_rdata[7:0] = acc_r;
            REG_STAT: begin
                reg_rdata[STAT_N_BIT] = flag_n_r;
                reg_rdata[STAT_Z_BIT] = flag_z_r;
                reg_rdata[STAT_SKIP_BIT] = state_r != ST_EXEC;
            end
            REG_SKIPS: reg_rdata[15:0] = skips_r;
            default: reg_rdata = 32'h00000000;
        endcase
    end

    // outputs straight from flip-flops, except skipping, which is decoded from state_r
    assign acc = acc_r;
    assign flag_n = flag_n_r;
    assign flag_z = flag_z_r;
    assign skipping = state_r != ST_EXEC;

    // a zero read discards the next word: no accumulator or zero flag change
    property p_skip_nop;
        @(posedge ref_clk) disable iff (!resetn)
        (do_tst && skip_hit && !reg_we) ##1 (instr_valid && !reg_we)
            |-> skipping ##1 (acc_r == $past(acc_r) && flag_z_r == $past(flag_z_r));
    endproperty
    a_skip_nop: assert property (p_skip_nop) else $error("skipped word was executed");

    // access bank outside the indexed window
    property p_access_bank;
        @(posedge ref_clk) disable iff (!resetn)
        (do_tst && !instr.word[A_BIT] && !(ctrl_r.xinst && instr.word[7:0] <= LIT_OFFSET_MAX))
            |-> mem_addr[11:8] == (instr.word[7:0] < ACCESS_SPLIT ? ACCESS_LO_BANK : ACCESS_HI_BANK)
                && mem_addr[7:0] == instr.word[7:0];
    endproperty
    a_access_bank: assert property (p_access_bank) else $error("access bank address wrong");

    // banked access follows the bank select register
    property p_banked;
        @(posedge ref_clk) disable iff (!resetn)
        (do_tst && instr.word[A_BIT]) |-> mem_addr == {ctrl_r.bank_select_register, instr.word[7:0]};
    endproperty
    a_banked: assert property (p_banked) else $error("banked address wrong");

    // indexed literal offset inside the window
    property p_indexed;
        @(posedge ref_clk) disable iff (!resetn)
        (do_tst && !instr.word[A_BIT] && ctrl_r.xinst && instr.word[7:0] <= LIT_OFFSET_MAX)
            |-> mem_addr == idx_base + {4'h0, instr.word[7:0]};
    endproperty
    a_indexed: assert property (p_indexed) else $error("indexed address wrong");

    // two-word skipped instruction holds off execution for two more words
    property p_three_cycle;
        @(posedge ref_clk) disable iff (!resetn)
        (state_r == ST_SKIP1 && take && instr.two_word) |=> state_r == ST_SKIP2 && !do_tst && !do_xor;
    endproperty
    a_three_cycle: assert property (p_three_cycle) else $error("two-word skip too short");

    // xor result and flags one edge after the instruction
    property p_xor;
        @(posedge ref_clk) disable iff (!resetn)
        do_xor |=> acc_r == ($past(acc_r) ^ $past(instr.word[7:0]))
            && flag_z_r == (acc_r == 8'h00) && flag_n_r == acc_r[7];
    endproperty
    a_xor: assert property (p_xor) else $error("xor result or flags wrong");

    // test-and-skip keeps both flags either way
    property p_flags_hold;
        @(posedge ref_clk) disable iff (!resetn)
        do_tst |=> $stable(flag_n_r) && $stable(flag_z_r);
    endproperty
    a_flags_hold: assert property (p_flags_hold) else $error("flags changed by test");

    // a nonzero file register costs one cycle and arms no discard
    property p_no_skip;
        @(posedge ref_clk) disable iff (!resetn)
        (do_tst && !skip_hit) |=> !skipping;
    endproperty
    a_no_skip: assert property (p_no_skip) else $error("skip armed on nonzero data");

    // a skipped one-word instruction costs exactly one extra cycle
    property p_single_skip;
        @(posedge ref_clk) disable iff (!resetn)
        (state_r == ST_SKIP1 && take && !instr.two_word) |=> state_r == ST_EXEC;
    endproperty
    a_single_skip: assert property (p_single_skip) else $error("one-word skip too long");

    // the tail of a skipped two-word instruction ends the discard
    property p_skip_tail_end;
        @(posedge ref_clk) disable iff (!resetn)
        (state_r == ST_SKIP2 && take) |=> state_r == ST_EXEC;
    endproperty
    a_skip_tail_end: assert property (p_skip_tail_end) else $error("two-word skip too long");
endmodule
`default_nettype wire

// ==== test/data_mem_model.sv ====
// behavioural data memory seen by the execution block's file read port
`timescale 1ns/1ps
`default_nettype none
module data_mem_model (
    input wire logic mem_rd,
    input wire logic [11:0] mem_addr,
    output logic [7:0] mem_rdata
);
    logic [7:0] mem [4096]; // file registers, preset by the bench
    logic [7:0] last_q = 8'h00; // last value handed out
    // nonzero fill so that only deliberate zeros cause a skip
    initial begin
        for (int i = 0; i < 4096; i++) begin
            mem[i] = 8'h5A;
        end
    end
    // same-cycle answer; when not read, show the inverse so stale data never passes
    always @* begin
        if (mem_rd) begin
            mem_rdata = mem[mem_addr];
            last_q = mem_rdata;
        end else begin
            mem_rdata = ~last_q;
        end
    end
endmodule
`default_nettype wire

// ==== test/test_skip_and_xor_literal_exec.sv ====
// self-checking bench for the skip and xor execution block
`timescale 1ns/1ps
`default_nettype none
module test_skip_and_xor_literal_exec;
    import exec_pkg::*;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hF;
    logic awready, wready, bvalid, arready, rvalid, instr_ready, mem_rd, flag_n, flag_z, skipping;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic instr_valid = 1'b0;
    instr_t instr = '0;
    logic [11:0] idx_base = 12'h123; // index base for literal offset rows
    logic [11:0] mem_addr;
    logic [7:0] mem_rdata, acc;
    int mismatches = 0, cmp_count = 0, cycles = 0;
    // address rows: ctrl word, a and f, expected file address
    logic [31:0] row_ctl [6] = '{32'h5, 32'h5, 32'h5, 32'h100, 32'h100, 32'h105};
    logic [8:0] row_af [6] = '{9'h120, 9'h010, 9'h080, 9'h05F, 9'h060, 9'h15F};
    logic [11:0] row_adr [6] = '{12'h520, 12'h010, 12'hF80, 12'h182, 12'hF60, 12'h55F};
    // xor rows: literal and accumulator expected afterwards
    logic [7:0] xk [4] = '{8'hB5, 8'hAF, 8'h1A, 8'h7F};
    logic [7:0] xa [4] = '{8'hB5, 8'h1A, 8'h00, 8'h7F};

    // 25 MHz clock
    always #20 ref_clk = ~ref_clk;

    skip_xor_exec i_dut (.ref_clk(ref_clk), .resetn(resetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .instr_valid(instr_valid), .instr(instr), .instr_ready(instr_ready), .idx_base(idx_base),
        .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_rdata(mem_rdata), .acc(acc), .flag_n(flag_n),
        .flag_z(flag_z), .skipping(skipping));

    data_mem_model i_mem (.mem_rd(mem_rd), .mem_addr(mem_addr), .mem_rdata(mem_rdata));

    // hang guard: a stuck handshake ends the run as a failure
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            mismatches++;
            test_done();
        end
    end

    // one comparison, counted
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // axi4-lite write; payload held until taken, bready held until bvalid seen
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge ref_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do @(negedge ref_clk); while (!(awready === 1'b1 && wready === 1'b1));
        @(posedge ref_clk);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        do @(negedge ref_clk); while (bvalid !== 1'b1);
        chk(bresp, er);
        @(posedge ref_clk);
        bready <= 1'b0;
    endtask

    // axi4-lite read with expected data and response
    task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge ref_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(negedge ref_clk); while (arready !== 1'b1);
        @(posedge ref_clk);
        arvalid <= 1'b0;
        do @(negedge ref_clk); while (rvalid !== 1'b1);
        chk(rdata, ed);
        chk(rresp, er);
        @(posedge ref_clk);
        rready <= 1'b0;
    endtask

    // present one fetched word for one cycle, return mid-cycle
    task automatic exec(input logic tw, input logic [15:0] w);
        @(posedge ref_clk);
        instr_valid <= 1'b1;
        instr <= '{two_word: tw, word: w};
        @(negedge ref_clk);
    endtask

    // no word from fetch
    task automatic idle();
        @(posedge ref_clk);
        instr_valid <= 1'b0;
        @(negedge ref_clk);
    endtask

    // single closing point
    task automatic test_done();
        $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (12) @(posedge ref_clk);
        resetn <= 1'b1;
        @(negedge ref_clk);
        // reset state and register bus
        chk({acc, flag_n, flag_z, skipping, instr_ready}, 12'h001);
        axi_rd(REG_CTRL, 32'h0, RESP_OKAY);
        axi_rd(REG_SKIPS, 32'h0, RESP_OKAY);
        axi_rd(8'h10, 32'h0, RESP_SLVERR);
        axi_wr(8'h10, 32'hFF, RESP_SLVERR);
        // xor rows, each result visible one cycle later
        for (int i = 0; i < 4; i++) begin
            exec(1'b0, {8'h0A, xk[i]});
            idle();
            chk({acc, flag_n, flag_z}, {xa[i], xa[i][7], xa[i] == 8'h00});
        end
        // address rows, each with a zero file register: skip discards the next xor
        for (int i = 0; i < 6; i++) begin
            axi_wr(REG_CTRL, row_ctl[i], RESP_OKAY);
            i_mem.mem[row_adr[i]] = 8'h00;
            exec(1'b0, {7'b0110011, row_af[i]});
            chk({mem_rd, mem_addr}, {1'b1, row_adr[i]});
            exec(1'b0, 16'h0AFF);
            chk(skipping, 1'b1);
            idle();
            chk({acc, flag_n, flag_z, skipping}, 11'h3F8);
            chk(i_mem.mem[row_adr[i]], 8'h00);
        end
        // nonzero file register: the following xor runs
        axi_wr(REG_CTRL, 32'h5, RESP_OKAY);
        i_mem.mem[12'h520] = 8'h01;
        exec(1'b0, 16'h6720);
        exec(1'b0, 16'h0AFF);
        chk(skipping, 1'b0);
        idle();
        chk({acc, flag_n, flag_z}, 10'h202);
        // skipped two-word instruction, followed at once by an xor
        i_mem.mem[12'h520] = 8'h00;
        exec(1'b0, 16'h6720);
        exec(1'b1, 16'h0A11);
        chk(skipping, 1'b1);
        exec(1'b0, 16'h0A22);
        chk(skipping, 1'b1);
        exec(1'b0, 16'h0A80);
        chk({skipping, acc}, {1'b0, 8'h80});
        idle();
        chk({acc, flag_n, flag_z}, 10'h001);
        // register readback
        axi_rd(REG_SKIPS, 32'h7, RESP_OKAY);
        axi_rd(REG_STAT, {29'h0, 1'b0, 1'b1, 1'b0}, RESP_OKAY);
        axi_wr(REG_ACC, 32'h3C, RESP_OKAY);
        axi_rd(REG_ACC, 32'h3C, RESP_OKAY);
        chk(acc, 8'h3C);
        test_done();
    end
endmodule
`default_nettype wire
